// >>> bench/nsdl_core_properties.sv
// Port checker for nsdl_core, attached by bind.
// Assumes one clock mclk and an async active-low rst_n.
`timescale 1ns/1ns
`default_nettype none
module nsdl_props (
    // Clock, reset, enable
    input wire logic        mclk,
    input wire logic        rst_n,
    input wire logic        ce,
    // Inputs
    input wire logic        instr_valid,
    input wire logic [13:0] instr,
    input wire logic [7:0]  file_rd_data,
    input wire logic [7:0]  acc_in,
    input wire logic        carry_in,
    input wire logic        bus_wr_en,
    input wire logic [6:0]  bus_addr,
    input wire logic [7:0]  bus_wr_data,
    // Outputs
    input wire logic        dir_hit,
    input wire logic        file_wr_en,
    input wire logic        acc_wr_en,
    input wire logic        carry_wr_en,
    input wire logic        carry_out,
    input wire logic        illegal_op,
    input wire logic [7:0]  file_wr_data,
    input wire logic [7:0]  acc_wr_data,
    input wire logic [7:0]  dir_a,
    input wire logic [7:0]  dir_b
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // Requests taken at an enabled edge
    sequence s_swap; ce && instr_valid && instr[13:8] == 6'h0e; endsequence
    sequence s_sub; ce && instr_valid && instr[13:8] == 6'h02; endsequence
    sequence s_dir; ce && instr_valid && instr[13:3] == 11'h00c; endsequence
    AST_SUB_CARRY: assert property (s_sub |=> carry_wr_en &&
        carry_out == ($past(file_rd_data) >= $past(acc_in))) else $error("bad carry");
    AST_SWAP_DATA: assert property (s_swap |=> ($past(instr[7]) ? file_wr_data : acc_wr_data)
        == {$past(file_rd_data[3:0]), $past(file_rd_data[7:4])}) else $error("bad swap");
    AST_SWAP_DEST: assert property (s_swap |=> file_wr_en == $past(instr[7]) &&
        acc_wr_en == !$past(instr[7])) else $error("bad swap target");
    AST_DIR_LOAD: assert property (s_dir ##0 instr[2:0] == 3'h6 |=> dir_b == $past(acc_in))
        else $error("bad dir load");
    AST_DIR_BAD: assert property (s_dir ##0 instr[2:0] < 3'h5 && !bus_wr_en |=>
        illegal_op && $stable(dir_b)) else $error("bad selector taken");
    AST_BUS_WR: assert property (ce && bus_wr_en && bus_addr == 7'h05 && !instr_valid
        |=> dir_a == $past(bus_wr_data)) else $error("bus write lost");
    AST_DIR_HIT: assert property (dir_hit == (bus_addr >= 7'h05 && bus_addr <= 7'h07))
        else $error("bad hit");
    AST_NO_FLAGS: assert property ((s_swap or s_dir) |=> !carry_wr_en)
        else $error("flag touched");
    AST_CARRY_KEEP: assert property ((s_swap or s_dir) |=> carry_out == $past(carry_in))
        else $error("carry not kept");
    AST_CE_FREEZE: assert property (!ce |=> $stable(dir_a) && $stable(dir_b) &&
        $stable(file_wr_en) && $stable(acc_wr_en) && $stable(carry_out))
        else $error("state moved with ce low");
endmodule // nsdl_props
bind nsdl_core nsdl_props nsdl_props_inst (.mclk, .rst_n, .ce, .instr_valid, .bus_wr_en, .instr,
    .carry_in,
    .file_rd_data, .acc_in, .bus_wr_data, .bus_addr, .dir_hit, .file_wr_en, .acc_wr_en,
    .carry_wr_en, .carry_out, .illegal_op, .file_wr_data, .acc_wr_data, .dir_a, .dir_b);
`default_nettype wire

// >>> bench/nsdl_core_tb.sv
// Self-checking bench for nsdl_core.
// Assumes the map header is on the include path; ce and carry_in are driven here.
`timescale 1ns/1ns
`default_nettype none
module nsdl_core_tb;
    logic        mclk = 0, rst_n = 0, instr_valid = 0, bus_wr_en = 0;
    logic        ce = 1, carry_in = 0;
    logic [13:0] instr = 0;
    logic [7:0]  file_rd_data = 0, acc_in = 0, bus_wr_data = 0;
    logic [6:0]  bus_addr = 0;
    wire  [7:0]  dir_rd_data, file_wr_data, acc_wr_data, dir_a, dir_b, dir_c;
    wire  [6:0]  file_addr;
    wire         dir_hit, file_wr_en, acc_wr_en, carry_wr_en, carry_out, illegal_op;
    int          bad_count = 0, checks = 0;
    nsdl_core nsdl_core_inst (.mclk, .rst_n, .ce, .instr_valid, .instr, .file_rd_data,
        .acc_in, .carry_in, .bus_wr_en, .bus_addr, .bus_wr_data, .dir_rd_data, .dir_hit,
        .file_addr, .file_wr_en, .file_wr_data, .acc_wr_en, .acc_wr_data, .carry_wr_en,
        .carry_out, .illegal_op, .dir_a, .dir_b, .dir_c);
    initial forever #10 mclk = ~mclk;
    task automatic cmp(input string what, input logic [7:0] exp, got);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Issue at the falling edge; results stand just after the next rising edge
    task automatic run(input logic [13:0] op, input logic [7:0] f, w);
        @(negedge mclk);
        instr_valid = 1;
        instr = op;
        file_rd_data = f;
        acc_in = w;
        @(posedge mclk);
        #1;
    endtask
    task automatic t_sub;
        for (int i = 0; i < 3; i++) begin
            run(14'h0285, 8'h03 - i[7:0], 8'h02);
            cmp("sub flags", {6'h00, 1'b1, i < 2}, {6'h00, carry_wr_en, carry_out});
            cmp("sub data", 8'h01 - i[7:0], file_wr_data);
        end
        $display("t_sub done");
    endtask
    task automatic t_swap;
        for (int d = 0; d < 2; d++) begin
            run({6'h0e, d[0], 7'h05}, 8'ha5, 8'h00);
            cmp("swap data", 8'h5a, d ? file_wr_data : acc_wr_data);
            cmp("swap en", {5'h00, d[0], !d[0], 1'b0}, {5'h00, file_wr_en, acc_wr_en, carry_wr_en});
        end
        $display("t_swap done");
    endtask
    task automatic t_dir;
        for (int s = 5; s < 8; s++) run({11'h00c, s[2:0]}, 8'h00, 8'h30 + s[7:0]);
        cmp("dir regs", 8'h35 ^ 8'h36 ^ 8'h37, dir_a ^ dir_b ^ dir_c);
        cmp("dir b", 8'h36, dir_b);
        run({11'h00c, 3'h4}, 8'h00, 8'hee);
        cmp("bad sel", {7'h00, 1'b1}, {7'h00, illegal_op});
        cmp("dir c kept", 8'h37, dir_c);
        $display("t_dir done");
    endtask
    task automatic t_bus;
        @(negedge mclk);
        instr_valid = 0;
        bus_wr_en = 1;
        bus_addr = 7'h05;
        bus_wr_data = 8'h5c;
        @(negedge mclk);
        bus_wr_en = 0;
        #1;
        cmp("dir a", 8'h5c, dir_a);
        cmp("bus read", 8'h5c, dir_rd_data);
        cmp("hit", 8'h01, {7'h00, dir_hit});
        bus_addr = 7'h08;
        #1;
        cmp("miss", 8'h00, {dir_hit, dir_rd_data[6:0]});
        $display("t_bus done");
    endtask
    // Clock enable low freezes state; a swap passes the carry through
    task automatic t_hold;
        @(negedge mclk);
        ce = 0;
        run({11'h00c, 3'h5}, 8'h00, 8'h99);
        cmp("ce hold", 8'h5c, dir_a);
        @(negedge mclk);
        ce = 1;
        instr_valid = 0;
        for (int c = 0; c < 2; c++) begin
            @(negedge mclk);
            carry_in = c[0];
            run({6'h0e, 1'b0, 7'h05}, 8'h12, 8'h00);
            cmp("swap carry", {7'h00, c[0]}, {6'h00, carry_wr_en, carry_out});
            cmp("swap acc", 8'h21, acc_wr_data);
        end
        $display("t_hold done");
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge mclk);
        @(negedge mclk) rst_n = 1;
        cmp("dir reset", 8'hff, dir_a & dir_b & dir_c);
        t_sub();
        t_swap();
        t_dir();
        t_bus();
        t_hold();
        report_and_stop();
    end
    // Hang guard
    initial begin
        #100000;
        bad_count++;
        report_and_stop();
    end
endmodule // nsdl_core_tb
`default_nettype wire

// >>> logic/nsdl_core.v
// Execution block: nibble exchange, direction load, file minus accumulator.
// Assumes the register file supplies the operand combinationally and
// takes file_wr_en/file_wr_data on the next clock edge when ce is high.
`timescale 1ns/1ns
`default_nettype none
`include "nsdl_map.vh"

module nsdl_core (
    // Clock, reset, enable
    input  wire                  mclk,
    input  wire                  rst_n,
    input  wire                  ce,
    // Instruction
    input  wire                  instr_valid,
    input  wire [`NSDL_IW-1:0]   instr,
    // Operands from register file and accumulator
    input  wire [`NSDL_DW-1:0]   file_rd_data,
    input  wire [`NSDL_DW-1:0]   acc_in,
    input  wire                  carry_in,
    // Ordinary file access to direction registers
    input  wire                  bus_wr_en,
    input  wire [`NSDL_FAW-1:0]  bus_addr,
    input  wire [`NSDL_DW-1:0]   bus_wr_data,
    output reg  [`NSDL_DW-1:0]   dir_rd_data,
    output reg                   dir_hit,
    // Results
    output wire [`NSDL_FAW-1:0]  file_addr,
    output reg                   file_wr_en,
    output reg  [`NSDL_DW-1:0]   file_wr_data,
    output reg                   acc_wr_en,
    output reg  [`NSDL_DW-1:0]   acc_wr_data,
    output reg                   carry_wr_en,
    output reg                   carry_out,
    output reg                   illegal_op,
    // Port direction registers (selectors 5, 6, 7)
    output reg  [`NSDL_DW-1:0]   dir_a,
    output reg  [`NSDL_DW-1:0]   dir_b,
    output reg  [`NSDL_DW-1:0]   dir_c
);

    // ----------------------------------------
    // Field widths
    // ----------------------------------------
    // Derived from the bit positions so the two cannot drift apart
    localparam OPW  = `NSDL_OP_HI - `NSDL_OP_LO + 1;
    localparam DIRW = `NSDL_DIR_HI - `NSDL_DIR_LO + 1;
    localparam SELW = `NSDL_SEL_HI - `NSDL_SEL_LO + 1;
    localparam PADW = `NSDL_FAW - SELW;

    // ----------------------------------------
    // Decode helpers
    // ----------------------------------------
    // Exchange the two nibbles of a byte
    function [`NSDL_DW-1:0] nsdl_swap;
        input [`NSDL_DW-1:0] v;
        nsdl_swap = {v[`NSDL_NIB_LO_HI:`NSDL_NIB_LO_LO],
                     v[`NSDL_NIB_HI_HI:`NSDL_NIB_HI_LO]};
    endfunction

    // Direction-register index from a file address, or the none code.
    // A load selector is the same address, so both paths share this
    // decode and can never disagree on which register is meant.
    function [`NSDL_IDX_HI:`NSDL_IDX_LO] nsdl_dir_idx;
        input [`NSDL_FAW-1:0] a;
        nsdl_dir_idx = (a >= `NSDL_FA_DIR0 && a <= `NSDL_FA_DIR2) ?
                       a[`NSDL_IDX_HI:`NSDL_IDX_LO] - `NSDL_FA_BIAS :
                       `NSDL_IDX_NONE;
    endfunction

    // ----------------------------------------
    // Instruction fields
    // ----------------------------------------
    wire [OPW-1:0]  opc     = instr[`NSDL_OP_HI:`NSDL_OP_LO];
    wire [DIRW-1:0] dir_pat = instr[`NSDL_DIR_HI:`NSDL_DIR_LO];
    wire [SELW-1:0] sel     = instr[`NSDL_SEL_HI:`NSDL_SEL_LO];
    wire            d_bit   = instr[`NSDL_D_BIT];

    // File address leaves combinationally so the register file can
    // present its operand within the same cycle
    assign file_addr = instr[`NSDL_F_HI:`NSDL_F_LO];

    // ----------------------------------------
    // Instruction decode
    // ----------------------------------------
    // Nothing decodes unless the word is marked valid
    wire is_swap = instr_valid && (opc == `NSDL_SWAP_OP);
    wire is_sub  = instr_valid && (opc == `NSDL_SUB_OP);
    wire is_dir  = instr_valid && (dir_pat == `NSDL_DIR_PAT);

    // Selectors below 5 name no direction register; refused and flagged on illegal_op
    wire dir_ok  = (sel >= `NSDL_SEL_MIN) && (sel <= `NSDL_SEL_MAX);

    // Shared index decode for the load selector and the file address
    wire [`NSDL_IDX_HI:`NSDL_IDX_LO] sel_idx = nsdl_dir_idx({{PADW{1'b0}}, sel});
    wire [`NSDL_IDX_HI:`NSDL_IDX_LO] bus_idx = nsdl_dir_idx(bus_addr);

    // ----------------------------------------
    // Arithmetic
    // ----------------------------------------
    // One extra bit catches the borrow; no borrow means carry set
    wire [`NSDL_DW:0] diff = {1'b0, file_rd_data} - {1'b0, acc_in};

    // ----------------------------------------
    // Next values of the result registers
    // ----------------------------------------
    reg                next_file_wr_en;
    reg                next_acc_wr_en;
    reg                next_carry_wr_en;
    reg                next_carry;
    reg                next_load;
    reg [`NSDL_DW-1:0] next_result;
    wire               next_illegal;

    // Both destinations see the same byte; only the enables differ
    always @* begin
        next_file_wr_en  = 1'b0;
        next_acc_wr_en   = 1'b0;
        next_carry_wr_en = 1'b0;
        next_carry       = carry_in;
        next_load        = 1'b0;
        next_result      = file_wr_data;
        if (is_swap) begin
            next_file_wr_en = d_bit;
            next_acc_wr_en  = !d_bit;
            next_load       = 1'b1;
            next_result     = nsdl_swap(file_rd_data);
        end else if (is_sub) begin
            next_file_wr_en  = d_bit;
            next_acc_wr_en   = !d_bit;
            next_load        = 1'b1;
            next_result      = diff[`NSDL_DW-1:0];
            next_carry_wr_en = 1'b1;
            next_carry       = ~diff[`NSDL_DW];
        end
    end

    // A refused direction load is flagged rather than silently dropped
    assign next_illegal = is_dir && !dir_ok;

    // ----------------------------------------
    // Result registers, one cycle per instruction
    // ----------------------------------------
    // Enables and strobes are single-cycle pulses; ce low freezes them
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            file_wr_en  <= 1'b0;
            acc_wr_en   <= 1'b0;
            carry_wr_en <= 1'b0;
            illegal_op  <= 1'b0;
        end else if (ce) begin
            file_wr_en  <= next_file_wr_en;
            acc_wr_en   <= next_acc_wr_en;
            carry_wr_en <= next_carry_wr_en;
            illegal_op  <= next_illegal;
        end
    end

    // Result data holds between swaps and subtracts, so the last
    // written value stays visible for the register file
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            file_wr_data <= `NSDL_DATA_RST;
            acc_wr_data  <= `NSDL_DATA_RST;
        end else if (ce && next_load) begin
            file_wr_data <= next_result;
            acc_wr_data  <= next_result;
        end
    end

    // Carry copy: new value after a subtract, the incoming carry otherwise
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            carry_out <= 1'b0;
        end else if (ce) begin
            carry_out <= next_carry;
        end
    end

    // ----------------------------------------
    // Direction register write select
    // ----------------------------------------
    reg [`NSDL_IDX_HI:`NSDL_IDX_LO] wr_idx;
    reg [`NSDL_DW-1:0]             wr_val;

    // Instruction load wins over a bus write in the same cycle; the bus
    // write is then lost, so software should not mix the two
    always @* begin
        wr_idx = `NSDL_IDX_NONE;
        wr_val = bus_wr_data;
        if (is_dir && dir_ok) begin
            wr_idx = sel_idx;
            wr_val = acc_in;
        end else if (bus_wr_en) begin
            wr_idx = bus_idx;
            wr_val = bus_wr_data;
        end
    end

    // ----------------------------------------
    // Direction registers
    // ----------------------------------------
    // Each register listens only to its own index
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            dir_a <= `NSDL_DIR_RST;
        end else if (ce && (wr_idx == `NSDL_IDX_A)) begin
            dir_a <= wr_val;
        end
    end

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            dir_b <= `NSDL_DIR_RST;
        end else if (ce && (wr_idx == `NSDL_IDX_B)) begin
            dir_b <= wr_val;
        end
    end

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            dir_c <= `NSDL_DIR_RST;
        end else if (ce && (wr_idx == `NSDL_IDX_C)) begin
            dir_c <= wr_val;
        end
    end

    // ----------------------------------------
    // Read path through file addressing
    // ----------------------------------------
    // Combinational so a file read sees the register in the same cycle;
    // a miss reads as zero and drops dir_hit
    always @* begin
        dir_hit     = 1'b1;
        dir_rd_data = `NSDL_DATA_RST;
        case (bus_idx)
            `NSDL_IDX_A: begin
                dir_rd_data = dir_a;
            end
            `NSDL_IDX_B: begin
                dir_rd_data = dir_b;
            end
            `NSDL_IDX_C: begin
                dir_rd_data = dir_c;
            end
            default: begin
                dir_hit     = 1'b0;
            end
        endcase
    end

endmodule // nsdl_core

`default_nettype wire

// >>> logic/nsdl_map.vh
// Opcode patterns, field positions and widths for the nibble-exchange,
// direction-load and file-minus-accumulator execution block.
// Assumes a 14-bit instruction word and an 8-bit data path.
// Notes on behaviour
// - File minus accumulator sets carry when the result is zero or positive, clears it on borrow.
// - Nibble exchange puts source bits 3:0 into result 7:4 and source 7:4 into result 3:0.
// - Nibble exchange writes the accumulator when the destination bit is 0, the file register when 1.
// - Direction load copies the accumulator into the direction register chosen by operands 5 to 7.
// - Direction registers are also read and written through ordinary file addressing.
`ifndef NSDL_MAP_VH
`define NSDL_MAP_VH

// ----------------------------------------
// Widths
// ----------------------------------------
`define NSDL_IW      14
`define NSDL_DW      8
`define NSDL_FAW     7

// ----------------------------------------
// Instruction fields
// ----------------------------------------
`define NSDL_OP_HI   13
`define NSDL_OP_LO   8
`define NSDL_D_BIT   7
`define NSDL_F_HI    6
`define NSDL_F_LO    0
`define NSDL_SWAP_OP 6'h0e
`define NSDL_SUB_OP  6'h02
`define NSDL_DIR_HI  13
`define NSDL_DIR_LO  3
`define NSDL_DIR_PAT 11'h00c
`define NSDL_SEL_HI  2
`define NSDL_SEL_LO  0

// ----------------------------------------
// Direction registers
// ----------------------------------------
`define NSDL_SEL_MIN 3'h5
`define NSDL_SEL_MAX 3'h7
`define NSDL_DIR_RST 8'hff
`define NSDL_NDIR    3
`define NSDL_FA_DIR0 7'h05
`define NSDL_FA_DIR2 7'h07
`define NSDL_FA_BANK 7'h00
`define NSDL_FA_BIAS 2'h1

// ----------------------------------------
// Direction register index codes
// ----------------------------------------
`define NSDL_IDX_HI   1
`define NSDL_IDX_LO   0
`define NSDL_IDX_A    2'h0
`define NSDL_IDX_B    2'h1
`define NSDL_IDX_C    2'h2
`define NSDL_IDX_NONE 2'h3

// ----------------------------------------
// Nibble positions and data reset
// ----------------------------------------
`define NSDL_NIB_HI_HI 7
`define NSDL_NIB_HI_LO 4
`define NSDL_NIB_LO_HI 3
`define NSDL_NIB_LO_LO 0
`define NSDL_DATA_RST  8'h00

`endif
